// File: src/citl_cpu.sv
// processor end: interrupt recognition, acknowledge and eoi cycles, trap detection
`timescale 1ns/1ns
`default_nettype none
module citl_cpu (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	citl_if.cpu              link,
	input  wire logic        boundary,
	input  wire logic        instr_check,
	input  wire logic [31:0] instr_addr,
	input  wire logic [31:0] next_addr,
	input  wire logic [31:0] vector_table_base,
	input  wire logic        psr_load,
	input  wire logic        psr_ie_in,
	input  wire logic        set_config_instr,
	input  wire logic        set_config_vectored,
	input  wire logic        return_from_irq_instr,
	input  wire logic        return_from_trap_instr,
	input  wire logic        user_mode,
	input  wire logic        privileged_op,
	input  wire logic        svc_instr,
	input  wire logic        bpt_instr,
	input  wire logic        flag_instr,
	input  wire logic        psr_flag_bit,
	input  wire logic        int_divide_zero,
	input  wire logic        slave_exception,
	input  wire logic        undefined_opcode,
	input  wire logic        float_instr,
	input  wire logic        cfg_float_en,
	input  wire logic        custom_instr,
	input  wire logic        cfg_custom_en,
	input  wire logic [4:0]  gen_mode,
	input  wire logic        imm_not_read,
	input  wire logic        nested_scaled,
	input  wire logic        slave_undefined,
	input  wire logic        psr_ovf_en,
	input  wire logic        ovf_detected,
	input  wire logic        trace_pending,
	input  wire logic        debug_cond,
	input  wire logic        debug_request_n,
	input  wire logic        pc_match_after_wait,
	output logic             exc_valid,
	output logic [7:0]       exc_vector,
	output logic [31:0]      exc_ret_addr,
	output logic             psr_ie,
	output logic             cfg_vectored,
	output logic             busy
);
	citl_pkg::citl_state_t st_q, st_d;         // bus sequencer state
	logic        req_q, req_d;                 // special cycle request
	logic [31:0] addr_q, addr_d;               // cycle address
	logic [4:0]  stat_q, stat_d;               // cycle status code
	logic        nmi_prev_q, nmi_prev_d;       // last nmi level
	logic        nmi_pend_q, nmi_pend_d;       // latched nmi edge
	logic        ie_q, ie_d;                   // status interrupt enable
	logic        saved_ie_q, saved_ie_d;       // enable copy for return
	logic        vect_q, vect_d;               // vectored mode
	logic        in_nmi_q, in_nmi_d;           // acknowledge is for nmi
	logic [31:0] ret_q, ret_d;                 // pending return address
	logic        ev_q, ev_d;                   // exception taken pulse
	logic [7:0]  vec_q, vec_d;                 // exception vector
	logic [31:0] eret_q, eret_d;               // exception return address
	logic        nmi_fall;                     // falling edge seen this cycle
	logic        nmi_take;                     // nmi accepted this cycle
	logic        dbg_now;                      // debug trap wanted
	logic        und_now;                      // undefined instruction
	logic [7:0]  trap_vec;                     // selected trap vector
	logic        trap_any;                     // some trap raised

	// cascade table entry address from a negative master vector
	function automatic logic [31:0] tbl_addr(input logic [31:0] base, input logic [7:0] idx);
		tbl_addr = base + {{22{idx[citl_pkg::SIGN_BIT]}}, idx, 2'b00};
	endfunction : tbl_addr

	// trap decode, prioritised instruction traps with undefined first, overflow last
	always_comb begin
		und_now = undefined_opcode | (float_instr & ~cfg_float_en)
			| (custom_instr & ~cfg_custom_en) | (gen_mode == citl_pkg::RESERVED_MODE)
			| imm_not_read | nested_scaled | slave_undefined;
		trap_any = 1'b1;
		if (und_now) begin
			trap_vec = citl_pkg::VEC_UND;
		end else if (privileged_op & user_mode) begin
			trap_vec = citl_pkg::VEC_ILL;
		end else if (svc_instr) begin
			trap_vec = citl_pkg::VEC_SVC;
		end else if (bpt_instr) begin
			trap_vec = citl_pkg::VEC_BPT;
		end else if (flag_instr & psr_flag_bit) begin
			trap_vec = citl_pkg::VEC_FLG;
		end else if (int_divide_zero) begin
			trap_vec = citl_pkg::VEC_DVZ;
		end else if (slave_exception) begin
			trap_vec = citl_pkg::VEC_SLAVE;
		end else if (psr_ovf_en & ovf_detected) begin
			trap_vec = citl_pkg::VEC_OVF;
		end else begin
			trap_vec = citl_pkg::VEC_NONVEC;
			trap_any = 1'b0;
		end
	end

	// recognition and bus sequencing, next values
	always_comb begin
		st_d       = st_q;
		req_d      = req_q;
		addr_d     = addr_q;
		stat_d     = stat_q;
		ie_d       = ie_q;
		saved_ie_d = saved_ie_q;
		vect_d     = vect_q;
		in_nmi_d   = in_nmi_q;
		ret_d      = ret_q;
		ev_d       = 1'b0;
		vec_d      = vec_q;
		eret_d     = eret_q;
		nmi_take   = 1'b0;
		nmi_prev_d = link.nmi_n;
		nmi_fall   = nmi_prev_q & ~link.nmi_n;
		dbg_now    = pc_match_after_wait | (boundary & (debug_cond | ~debug_request_n));
		if (psr_load) begin
			ie_d = psr_ie_in;
		end
		if (set_config_instr) begin
			vect_d = set_config_vectored;
		end
		unique case (st_q)
			citl_pkg::CITL_IDLE: begin
				if (return_from_irq_instr) begin
					ie_d   = saved_ie_q;
					req_d  = 1'b1;
					addr_d = citl_pkg::ACK_MASTER_ADDR;
					stat_d = citl_pkg::ST_EOI_MASTER;
					st_d   = citl_pkg::CITL_MEOI;
				end else if (return_from_trap_instr) begin
					ie_d = saved_ie_q;
				end else if (dbg_now) begin
					saved_ie_d = ie_d;
					ie_d       = 1'b0;
					ev_d       = 1'b1;
					vec_d      = citl_pkg::VEC_DBG;
					eret_d     = next_addr;
				end else if (boundary & nmi_pend_q) begin
					nmi_take   = 1'b1;
					saved_ie_d = ie_d;
					ie_d       = 1'b0;
					in_nmi_d   = 1'b1;
					ret_d      = next_addr;
					req_d      = 1'b1;
					addr_d     = citl_pkg::NMI_ACK_ADDR;
					stat_d     = citl_pkg::ST_ACK_MASTER;
					st_d       = citl_pkg::CITL_MACK;
				end else if (boundary & ie_q & ~link.int_n) begin
					saved_ie_d = ie_d;
					ie_d       = 1'b0;
					in_nmi_d   = 1'b0;
					ret_d      = next_addr;
					req_d      = 1'b1;
					addr_d     = citl_pkg::ACK_MASTER_ADDR;
					stat_d     = citl_pkg::ST_ACK_MASTER;
					st_d       = citl_pkg::CITL_MACK;
				end else if (boundary & trace_pending) begin
					ev_d   = 1'b1;
					vec_d  = citl_pkg::VEC_TRC;
					eret_d = next_addr;
				end else if (instr_check & trap_any) begin
					ev_d   = 1'b1;
					vec_d  = trap_vec;
					eret_d = instr_addr;
				end
			end
			citl_pkg::CITL_MACK: begin
				if (link.bus_ack) begin
					req_d = 1'b0;
					if (in_nmi_q) begin
						ev_d  = 1'b1;
						vec_d = citl_pkg::VEC_NMI;
						eret_d = ret_q;
						st_d  = citl_pkg::CITL_IDLE;
					end else if (!vect_q) begin
						ev_d  = 1'b1;
						vec_d = citl_pkg::VEC_NONVEC;
						eret_d = ret_q;
						st_d  = citl_pkg::CITL_IDLE;
					end else if (link.bus_rdata[citl_pkg::SIGN_BIT]) begin
						req_d  = 1'b1;
						addr_d = tbl_addr(vector_table_base, link.bus_rdata[7:0]);
						stat_d = citl_pkg::ST_TABLE_READ;
						st_d   = citl_pkg::CITL_TBL;
					end else begin
						ev_d  = 1'b1;
						vec_d = link.bus_rdata[7:0];
						eret_d = ret_q;
						st_d  = citl_pkg::CITL_IDLE;
					end
				end
			end
			citl_pkg::CITL_TBL: begin
				if (link.bus_ack) begin
					addr_d = link.bus_rdata;
					stat_d = citl_pkg::ST_ACK_CASC;
					st_d   = citl_pkg::CITL_CACK;
				end
			end
			citl_pkg::CITL_CACK: begin
				if (link.bus_ack) begin
					req_d  = 1'b0;
					ev_d   = 1'b1;
					vec_d  = link.bus_rdata[7:0];
					eret_d = ret_q;
					st_d   = citl_pkg::CITL_IDLE;
				end
			end
			citl_pkg::CITL_MEOI: begin
				if (link.bus_ack) begin
					if (link.bus_rdata[citl_pkg::SIGN_BIT]) begin
						addr_d = tbl_addr(vector_table_base, link.bus_rdata[7:0]);
						stat_d = citl_pkg::ST_TABLE_READ;
						st_d   = citl_pkg::CITL_ETBL;
					end else begin
						req_d = 1'b0;
						st_d  = citl_pkg::CITL_IDLE;
					end
				end
			end
			citl_pkg::CITL_ETBL: begin
				if (link.bus_ack) begin
					addr_d = link.bus_rdata;
					stat_d = citl_pkg::ST_EOI_CASC;
					st_d   = citl_pkg::CITL_CEOI;
				end
			end
			citl_pkg::CITL_CEOI: begin
				if (link.bus_ack) begin
					req_d = 1'b0;
					st_d  = citl_pkg::CITL_IDLE;
				end
			end
			default: begin
				req_d = 1'b0;
				st_d  = citl_pkg::CITL_IDLE;
			end
		endcase
		nmi_pend_d = nmi_fall | (nmi_pend_q & ~nmi_take);
	end

	// registers, frozen while clk_en is low
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q       <= citl_pkg::CITL_IDLE;
			req_q      <= 1'b0;
			addr_q     <= 32'h0000_0000;
			stat_q     <= 5'h00;
			nmi_prev_q <= 1'b1;
			nmi_pend_q <= 1'b0;
			ie_q       <= 1'b0;
			saved_ie_q <= 1'b0;
			vect_q     <= 1'b0;
			in_nmi_q   <= 1'b0;
			ret_q      <= 32'h0000_0000;
			ev_q       <= 1'b0;
			vec_q      <= 8'h00;
			eret_q     <= 32'h0000_0000;
		end else if (clk_en) begin
			st_q       <= st_d;
			req_q      <= req_d;
			addr_q     <= addr_d;
			stat_q     <= stat_d;
			nmi_prev_q <= nmi_prev_d;
			nmi_pend_q <= nmi_pend_d;
			ie_q       <= ie_d;
			saved_ie_q <= saved_ie_d;
			vect_q     <= vect_d;
			in_nmi_q   <= in_nmi_d;
			ret_q      <= ret_d;
			ev_q       <= ev_d;
			vec_q      <= vec_d;
			eret_q     <= eret_d;
		end
	end

	// outputs straight from flops
	assign link.bus_req    = req_q;
	assign link.bus_addr   = addr_q;
	assign link.bus_status = stat_q;
	assign exc_valid       = ev_q;
	assign exc_vector      = vec_q;
	assign exc_ret_addr    = eret_q;
	assign psr_ie          = ie_q;
	assign cfg_vectored    = vect_q;
	assign busy            = req_q;
endmodule : citl_cpu
`default_nettype wire

// File: src/citl_pkg.sv
// constants, codes and state types of the interrupt and trap logic
package citl_pkg;
	localparam logic [31:0] ACK_MASTER_ADDR = 32'h0fff_fe00; // maskable acknowledge / eoi address
	localparam logic [31:0] NMI_ACK_ADDR    = 32'h0fff_ff00; // non-maskable acknowledge address
	localparam logic [4:0]  ST_ACK_MASTER   = 5'h04;         // interrupt acknowledge, master
	localparam logic [4:0]  ST_ACK_CASC     = 5'h05;         // interrupt acknowledge, cascaded
	localparam logic [4:0]  ST_EOI_MASTER   = 5'h06;         // end of interrupt, master
	localparam logic [4:0]  ST_EOI_CASC     = 5'h07;         // end of interrupt, cascaded
	localparam logic [4:0]  ST_TABLE_READ   = 5'h0a;         // cascade table data read
	localparam logic [4:0]  RESERVED_MODE   = 5'h13;         // reserved addressing encoding
	localparam int          SIGN_BIT        = 7;             // sign bit of a master vector
	localparam int          TBL_IDX_LSB     = 2;             // table entries are words
	localparam int          TBL_IDX_MSB     = 5;             // 16 entries below the base
	localparam int          TBL_DEPTH       = 16;            // cascaded units at most
	// vectors of each exception source
	localparam logic [7:0]  VEC_NONVEC      = 8'h00;
	localparam logic [7:0]  VEC_NMI         = 8'h01;
	localparam logic [7:0]  VEC_SLAVE       = 8'h03;
	localparam logic [7:0]  VEC_ILL         = 8'h04;
	localparam logic [7:0]  VEC_SVC         = 8'h05;
	localparam logic [7:0]  VEC_DVZ         = 8'h06;
	localparam logic [7:0]  VEC_FLG         = 8'h07;
	localparam logic [7:0]  VEC_BPT         = 8'h08;
	localparam logic [7:0]  VEC_TRC         = 8'h09;
	localparam logic [7:0]  VEC_UND         = 8'h0a;
	localparam logic [7:0]  VEC_OVF         = 8'h0d;
	localparam logic [7:0]  VEC_DBG         = 8'h0e;
	// bus sequencer states of the processor end
	typedef enum logic [6:0] {
		CITL_IDLE = 7'h01,
		CITL_MACK = 7'h02,
		CITL_TBL  = 7'h04,
		CITL_CACK = 7'h08,
		CITL_MEOI = 7'h10,
		CITL_ETBL = 7'h20,
		CITL_CEOI = 7'h40
	} citl_state_t;
endpackage : citl_pkg

// File: src/citl_if.sv
// link between the processor end and the interrupt control unit end
`timescale 1ns/1ns
`default_nettype none
interface citl_if;
	logic        int_n;       // maskable request, low active level
	logic        nmi_n;       // non-maskable request, falling edge
	logic        bus_req;     // special bus cycle requested
	logic [31:0] bus_addr;    // address of the cycle
	logic [4:0]  bus_status;  // status code of the cycle
	logic        bus_ack;     // one-cycle answer
	logic [31:0] bus_rdata;   // data read, valid with bus_ack
	modport cpu (input int_n, nmi_n, bus_ack, bus_rdata, output bus_req, bus_addr, bus_status);
	modport icu (output int_n, nmi_n, bus_ack, bus_rdata, input bus_req, bus_addr, bus_status);
endinterface : citl_if
`default_nettype wire

// File: src/citl_icu.sv
// controller end: master unit, cascade table store and cascaded units
`timescale 1ns/1ns
`default_nettype none
module citl_icu (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	citl_if.icu              link,
	input  wire logic        irq_pending,
	input  wire logic [7:0]  master_vector,
	input  wire logic [7:0]  casc_vector,
	input  wire logic        nmi_request,
	input  wire logic        tbl_we,
	input  wire logic [3:0]  tbl_idx,
	input  wire logic [31:0] tbl_data,
	output logic             eoi_master,
	output logic             eoi_casc,
	output logic [7:0]       last_vector
);
	logic [31:0] tbl_q [citl_pkg::TBL_DEPTH]; // cascade table entries
	logic [31:0] tbl_d [citl_pkg::TBL_DEPTH];
	logic        int_q, int_d;         // request level, low active
	logic        nmi_q, nmi_d;         // nmi level, low active
	logic        ack_q, ack_d;         // answer pulse
	logic [31:0] rd_q, rd_d;           // answer data
	logic [7:0]  lv_q, lv_d;           // vector in service
	logic        em_q, em_d;           // master eoi seen
	logic        ec_q, ec_d;           // cascaded eoi seen

	// answers one cycle after a request, one pulse per cycle
	always_comb begin
		tbl_d = tbl_q;
		int_d = ~irq_pending;
		nmi_d = ~nmi_request;
		ack_d = link.bus_req & ~ack_q;
		rd_d  = rd_q;
		lv_d  = lv_q;
		em_d  = 1'b0;
		ec_d  = 1'b0;
		if (tbl_we) begin
			tbl_d[tbl_idx] = tbl_data;
		end
		if (link.bus_req & ~ack_q) begin
			unique case (link.bus_status)
				citl_pkg::ST_ACK_MASTER: begin
					rd_d = {24'h000000, master_vector};
					lv_d = master_vector;
				end
				citl_pkg::ST_EOI_MASTER: begin
					rd_d = {24'h000000, lv_q};
					em_d = 1'b1;
				end
				citl_pkg::ST_TABLE_READ: begin
					rd_d = tbl_q[link.bus_addr[citl_pkg::TBL_IDX_MSB:citl_pkg::TBL_IDX_LSB]];
				end
				citl_pkg::ST_ACK_CASC: begin
					rd_d = {24'h000000, casc_vector};
				end
				citl_pkg::ST_EOI_CASC: begin
					rd_d = {24'h000000, casc_vector};
					ec_d = 1'b1;
				end
				default: begin
					rd_d = 32'h0000_0000;
				end
			endcase
		end
	end

	// registers, frozen while clk_en is low
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < citl_pkg::TBL_DEPTH; i++) begin
				tbl_q[i] <= 32'h0000_0000;
			end
			int_q <= 1'b1;
			nmi_q <= 1'b1;
			ack_q <= 1'b0;
			rd_q  <= 32'h0000_0000;
			lv_q  <= 8'h00;
			em_q  <= 1'b0;
			ec_q  <= 1'b0;
		end else if (clk_en) begin
			tbl_q <= tbl_d;
			int_q <= int_d;
			nmi_q <= nmi_d;
			ack_q <= ack_d;
			rd_q  <= rd_d;
			lv_q  <= lv_d;
			em_q  <= em_d;
			ec_q  <= ec_d;
		end
	end

	assign link.int_n     = int_q;
	assign link.nmi_n     = nmi_q;
	assign link.bus_ack   = ack_q;
	assign link.bus_rdata = rd_q;
	assign eoi_master     = em_q;
	assign eoi_casc       = ec_q;
	assign last_vector    = lv_q;
endmodule : citl_icu
`default_nettype wire

// File: tb/citl_props.sv
// assertion checker watching the special-cycle link between both ends
`timescale 1ns/1ns
`default_nettype none
module citl_props (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        int_n,
	input  wire logic        nmi_n,
	input  wire logic        bus_req,
	input  wire logic [31:0] bus_addr,
	input  wire logic [4:0]  bus_status,
	input  wire logic        bus_ack,
	input  wire logic [31:0] bus_rdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic       eoi_done;  // master eoi answered this cycle
	logic       tbl_done;  // cascade table word answered this cycle
	logic [3:0] casc_idx;  // low bits of the byte just read
	assign eoi_done = bus_ack && bus_status == citl_pkg::ST_EOI_MASTER;
	assign tbl_done = bus_ack && bus_status == citl_pkg::ST_TABLE_READ;
	assign casc_idx = bus_rdata[3:0];
	// answer is a single cycle pulse
	ack_pulse_a: assert property (bus_ack |=> !bus_ack)
		else $error("acknowledge held longer than one cycle");
	// a fresh request is answered one cycle later
	ack_answer_a: assert property ($rose(bus_req) |=> bus_ack)
		else $error("special cycle not answered in time");
	// request and its qualifiers hold until answered
	req_hold_a: assert property (bus_req && !bus_ack |=>
		bus_req && $stable(bus_addr) && $stable(bus_status))
		else $error("special cycle changed before its answer");
	// master acknowledge only at the two fixed addresses
	ack_addr_a: assert property (bus_req && bus_status == citl_pkg::ST_ACK_MASTER |->
		bus_addr == citl_pkg::ACK_MASTER_ADDR || bus_addr == citl_pkg::NMI_ACK_ADDR)
		else $error("master acknowledge at a wrong address");
	// master eoi at the maskable acknowledge address
	eoi_addr_a: assert property (bus_req && bus_status == citl_pkg::ST_EOI_MASTER |->
		bus_addr == citl_pkg::ACK_MASTER_ADDR)
		else $error("master eoi at a wrong address");
	// positive eoi byte ends the return sequence
	eoi_plain_a: assert property (eoi_done && !bus_rdata[7] |=> !bus_req)
		else $error("cascaded eoi work after a positive byte");
	// negative eoi byte fetches its table entry below the base
	eoi_table_a: assert property (eoi_done && bus_rdata[7] |=> bus_req &&
		bus_status == citl_pkg::ST_TABLE_READ && bus_addr[5:2] == $past(casc_idx))
		else $error("negative eoi byte not followed by its table read");
	// cascaded cycle runs at the table word just read
	casc_addr_a: assert property (tbl_done |=> bus_req &&
		bus_addr == $past(bus_rdata) &&
		(bus_status == citl_pkg::ST_ACK_CASC || bus_status == citl_pkg::ST_EOI_CASC))
		else $error("cascaded cycle not at the table address");
	// cascaded answer closes the chain
	casc_done_a: assert property (bus_ack && (bus_status == citl_pkg::ST_ACK_CASC ||
		bus_status == citl_pkg::ST_EOI_CASC) |=> !bus_req)
		else $error("bus still requested after cascaded cycle");
	// falling nmi leads to its fixed acknowledge
	nmi_ack_a: assert property ($fell(nmi_n) |-> ##[1:30] (bus_req &&
		bus_addr == citl_pkg::NMI_ACK_ADDR && bus_status == citl_pkg::ST_ACK_MASTER))
		else $error("nmi edge without its acknowledge cycle");
	cover property (bus_ack && bus_status == citl_pkg::ST_ACK_CASC);
	cover property (bus_ack && bus_status == citl_pkg::ST_EOI_CASC);
	cover property (bus_ack && bus_addr == citl_pkg::NMI_ACK_ADDR);
	cover property (!int_n && bus_req);
endmodule : citl_props
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench joining the processor end and the controller end
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
	logic        sys_clk = 1'b0;   // 25 MHz clock
	logic        reset_n = 1'b0;   // async, active low
	logic        clk_en = 1'b1;    // low freezes both ends
	logic        boundary = 1'b1;  // every cycle is a boundary
	logic        instr_check = 1'b0, psr_load = 1'b0, psr_ie_in = 1'b1;
	logic        set_config_instr = 1'b0, set_config_vectored = 1'b0;
	logic        return_from_irq_instr = 1'b0, return_from_trap_instr = 1'b0;
	logic        trace_pending = 1'b0, debug_cond = 1'b0, pc_match_after_wait = 1'b0;
	logic        debug_request_n = 1'b1, irq_pending = 1'b0, nmi_request = 1'b0, tbl_we = 1'b0;
	logic        user_mode, privileged_op, svc_instr, bpt_instr, flag_instr, psr_flag_bit;
	logic        int_divide_zero, slave_exception, undefined_opcode, float_instr, cfg_float_en;
	logic        custom_instr, cfg_custom_en, imm_not_read, nested_scaled, slave_undefined;
	logic        psr_ovf_en, ovf_detected;
	logic [17:0] trap_bits = 18'h0;  // packed trap inputs
	logic [4:0]  gen_mode = 5'h00;
	logic [3:0]  tbl_idx = 4'h0;
	logic [7:0]  master_vector = 8'h00, casc_vector = 8'h00, tvec;
	logic [31:0] instr_addr = 32'h0, next_addr = 32'h0, tbl_data = 32'h0;
	logic [31:0] vector_table_base = 32'h0;
	logic        exc_valid, psr_ie, cfg_vectored, busy, eoi_master, eoi_casc;
	logic [7:0]  exc_vector, last_vector;
	logic [31:0] exc_ret_addr;
	logic [39:0] notes[$];  // expected vector and return address
	logic [39:0] exp_note;
	logic [31:0] seed = 32'h2aea;  // xorshift state
	int          mismatches = 0, checked = 0, eoi_m = 0, eoi_c = 0, eoi_ref;
	assign {ovf_detected, psr_ovf_en, slave_undefined, nested_scaled, imm_not_read, cfg_custom_en,
		custom_instr, cfg_float_en, float_instr, undefined_opcode, slave_exception,
		int_divide_zero, psr_flag_bit, flag_instr, bpt_instr, svc_instr, privileged_op,
		user_mode} = trap_bits;
	always #20 sys_clk = ~sys_clk;
	citl_if u_citl_if ();
	citl_cpu u_citl_cpu (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
		.link(u_citl_if.cpu), .boundary(boundary), .instr_check(instr_check),
		.instr_addr(instr_addr), .next_addr(next_addr),
		.vector_table_base(vector_table_base), .psr_load(psr_load),
		.psr_ie_in(psr_ie_in), .set_config_instr(set_config_instr),
		.set_config_vectored(set_config_vectored),
		.return_from_irq_instr(return_from_irq_instr),
		.return_from_trap_instr(return_from_trap_instr), .user_mode(user_mode),
		.privileged_op(privileged_op), .svc_instr(svc_instr), .bpt_instr(bpt_instr),
		.flag_instr(flag_instr), .psr_flag_bit(psr_flag_bit),
		.int_divide_zero(int_divide_zero), .slave_exception(slave_exception),
		.undefined_opcode(undefined_opcode), .float_instr(float_instr),
		.cfg_float_en(cfg_float_en), .custom_instr(custom_instr),
		.cfg_custom_en(cfg_custom_en), .gen_mode(gen_mode), .imm_not_read(imm_not_read),
		.nested_scaled(nested_scaled), .slave_undefined(slave_undefined),
		.psr_ovf_en(psr_ovf_en), .ovf_detected(ovf_detected),
		.trace_pending(trace_pending), .debug_cond(debug_cond),
		.debug_request_n(debug_request_n), .pc_match_after_wait(pc_match_after_wait),
		.exc_valid(exc_valid), .exc_vector(exc_vector), .exc_ret_addr(exc_ret_addr),
		.psr_ie(psr_ie), .cfg_vectored(cfg_vectored), .busy(busy));
	citl_icu u_citl_icu (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
		.link(u_citl_if.icu), .irq_pending(irq_pending), .master_vector(master_vector),
		.casc_vector(casc_vector), .nmi_request(nmi_request), .tbl_we(tbl_we),
		.tbl_idx(tbl_idx), .tbl_data(tbl_data), .eoi_master(eoi_master),
		.eoi_casc(eoi_casc), .last_vector(last_vector));
	citl_props u_citl_props (.sys_clk(sys_clk), .reset_n(reset_n), .int_n(u_citl_if.int_n),
		.nmi_n(u_citl_if.nmi_n), .bus_req(u_citl_if.bus_req), .bus_addr(u_citl_if.bus_addr),
		.bus_status(u_citl_if.bus_status), .bus_ack(u_citl_if.bus_ack),
		.bus_rdata(u_citl_if.bus_rdata));
	// compare each exception taken with the oldest note, count eoi pulses
	always @(negedge sys_clk) begin
		if (eoi_master === 1'b1) eoi_m++;
		if (eoi_casc === 1'b1) eoi_c++;
		if (exc_valid === 1'b1) begin
			exp_note = (notes.size() != 0) ? notes.pop_front() : {40{1'bx}};
			`CHK({exc_vector, exc_ret_addr}, exp_note)
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs
	// trap input set, addressing mode, vector (ff: none expected)
	function automatic logic [30:0] trap_case(input int i);
		case (i)
			0: return {18'h00003, 5'h00, citl_pkg::VEC_ILL};
			1: return {18'h00004, 5'h00, citl_pkg::VEC_SVC};
			2: return {18'h00008, 5'h00, citl_pkg::VEC_BPT};
			3: return {18'h00030, 5'h00, citl_pkg::VEC_FLG};
			4: return {18'h00040, 5'h00, citl_pkg::VEC_DVZ};
			5: return {18'h00080, 5'h00, citl_pkg::VEC_SLAVE};
			6: return {18'h00100, 5'h00, citl_pkg::VEC_UND};
			7: return {18'h00200, 5'h00, citl_pkg::VEC_UND};
			8: return {18'h00800, 5'h00, citl_pkg::VEC_UND};
			9: return {18'h00000, citl_pkg::RESERVED_MODE, citl_pkg::VEC_UND};
			10: return {18'h02000, 5'h00, citl_pkg::VEC_UND};
			11: return {18'h04000, 5'h00, citl_pkg::VEC_UND};
			12: return {18'h08000, 5'h00, citl_pkg::VEC_UND};
			13: return {18'h30000, 5'h00, citl_pkg::VEC_OVF};
			14: return {18'h00803, 5'h00, citl_pkg::VEC_UND};
			15: return {18'h00010, 5'h00, 8'hff};
			16: return {18'h20000, 5'h00, 8'hff};
			17: return {18'h00600, 5'h00, 8'hff};
			18: return {18'h00002, 5'h00, 8'hff};
			default: return {18'h01800, 5'h00, 8'hff};
		endcase
	endfunction : trap_case
	task step();
		@(posedge sys_clk);
		#1;
	endtask : step
	// one-cycle strobe on any bench input
	task automatic pulse(ref logic s, input logic v);
		s = v;
		step();
		s = ~v;
	endtask : pulse
	task wait_q(input int n);
		for (int i = 0; i < 80 && notes.size() > n; i++) step();
		`CHK(notes.size(), n)
	endtask : wait_q
	task wait_idle();
		step();
		step();
		for (int i = 0; i < 40 && busy !== 1'b0; i++) step();
		`CHK(busy, 1'b0)
	endtask : wait_idle
	task set_cfg(input logic v);
		set_config_vectored = v;
		pulse(set_config_instr, 1'b1);
		step();
		`CHK(cfg_vectored, v)
	endtask : set_cfg
	// maskable request held for reps services, then return with eoi
	task automatic irq_run(input logic vmode, input logic casc, input int reps);
		logic [7:0] vec;
		int m0, c0;
		seed = xs(seed);
		master_vector = casc ? {4'hf, seed[3:0]} : {1'b0, seed[6:0]};
		casc_vector = seed[15:8];
		next_addr = seed;
		vector_table_base = {seed[31:6], 6'h00};
		tbl_idx = seed[3:0];
		tbl_data = {seed[15:0], seed[31:16]};
		vec = !vmode ? citl_pkg::VEC_NONVEC : casc ? casc_vector : master_vector;
		pulse(tbl_we, 1'b1);
		for (int r = 0; r < reps; r++) notes.push_back({vec, next_addr});
		irq_pending = 1'b1;
		for (int r = reps; r > 0; r--) begin
			pulse(psr_load, 1'b1);
			wait_q(r - 1);
		end
		irq_pending = 1'b0;
		wait_idle();
		`CHK(psr_ie, 1'b0)
		`CHK(last_vector, master_vector)
		m0 = eoi_m;
		c0 = eoi_c;
		pulse(return_from_irq_instr, 1'b1);
		wait_idle();
		`CHK(eoi_m - m0, 1)
		`CHK(eoi_c - c0, int'(casc))
		`CHK(psr_ie, 1'b1)
	endtask : irq_run
	task end_of_test();
		$display("checked %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		irq_pending = 1'b1;
		repeat (10) step();
		`CHK(busy, 1'b0)
		irq_pending = 1'b0;
		set_cfg(1'b0);
		irq_run(1'b0, 1'b0, 1);
		irq_run(1'b0, 1'b1, 1);
		set_cfg(1'b1);
		irq_run(1'b1, 1'b0, 2);
		for (int i = 0; i < 3; i++) irq_run(1'b1, 1'b1, 1);
		// trap table, faulting address saved
		for (int i = 0; i < 20; i++) begin
			{trap_bits, gen_mode, tvec} = trap_case(i);
			seed = xs(seed);
			instr_addr = seed;
			if (tvec != 8'hff) notes.push_back({tvec, instr_addr});
			pulse(instr_check, 1'b1);
			trap_bits = 18'h0;
			gen_mode = 5'h00;
			wait_q(0);
			step();
			`CHK(psr_ie, 1'b1)
		end
		// three debug sources, then trace
		for (int i = 0; i < 4; i++) begin
			pulse(psr_load, 1'b1);
			seed = xs(seed);
			next_addr = seed;
			notes.push_back({(i < 3) ? citl_pkg::VEC_DBG : citl_pkg::VEC_TRC, next_addr});
			case (i)
				0: pulse(debug_cond, 1'b1);
				1: pulse(debug_request_n, 1'b0);
				2: pulse(pc_match_after_wait, 1'b1);
				default: pulse(trace_pending, 1'b1);
			endcase
			wait_q(0);
			step();
			`CHK(psr_ie, i == 3)
		end
		// nmi, then return by the trap path with no bus cycle
		notes.push_back({citl_pkg::VEC_NMI, next_addr});
		pulse(nmi_request, 1'b1);
		wait_q(0);
		wait_idle();
		`CHK(psr_ie, 1'b0)
		eoi_ref = eoi_m;
		pulse(return_from_trap_instr, 1'b1);
		repeat (4) begin
			`CHK(busy, 1'b0)
			step();
		end
		`CHK(eoi_m, eoi_ref)
		`CHK(psr_ie, 1'b1)
		// enable loaded clear, then a held request is ignored
		psr_ie_in = 1'b0;
		pulse(psr_load, 1'b1);
		irq_pending = 1'b1;
		repeat (6) step();
		`CHK(psr_ie, 1'b0)
		`CHK(busy, 1'b0)
		// frozen clock enable drops a configuration strobe
		clk_en = 1'b0;
		set_config_vectored = 1'b0;
		pulse(set_config_instr, 1'b1);
		clk_en = 1'b1;
		step();
		`CHK(cfg_vectored, 1'b1)
		end_of_test();
	end
	// watchdog against a hang
	initial begin
		#400000;
		mismatches++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
